// ### logic/cfg_port_device.sv
// device end of the configuration port with its byte register space
// assumes link pins are asynchronous and sampled on the system clock
`default_nettype none

module cfg_port_device (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // link
  cfg_port_if.device link,
  // user side
  output logic [7:0] o_out_fmt,
  output logic [1:0] o_chan_sel,
  output logic o_soft_reset_busy,
  output logic o_pins_idle
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic sclk_d_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // idle pin levels: select high, clock low, wire pulled high; no false edge
      meta_r <= 3'h5;
      sync_r <= 3'h5;
      sclk_d_r <= 1'b0;
    end else begin
      meta_r <= {link.port_select_n, link.sclk, link.sdio};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[1];
    end
  end
  wire sel_n = sync_r[2];
  wire sdi = sync_r[0];
  wire sclk_rise = sync_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sync_r[1] & sclk_d_r;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] iface_r;
  logic [7:0] chan_r;
  logic [7:0] scratch_r;
  logic [7:0] fmt_a_r;
  logic [7:0] fmt_b_r;
  logic [22:0] srst_cnt_r;
  wire lsb_first = iface_r[cfg_port_pkg::IFACE_LSB_BIT];
  wire ascend = iface_r[cfg_port_pkg::IFACE_ASC_BIT];

  // ****************************************
  // frame state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} fr_state_t;
  fr_state_t state_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] instr_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic is_read_r;
  logic [14:0] addr_r;
  logic drive_r;
  logic dout_r;

  // address decode, unassigned reads zero
  wire in_map = (addr_r <= cfg_port_pkg::SEC0_HI) |
    (addr_r >= cfg_port_pkg::SEC1_LO && addr_r <= cfg_port_pkg::SEC1_HI) |
    (addr_r >= cfg_port_pkg::SEC2_LO && addr_r <= cfg_port_pkg::SEC2_HI) |
    (addr_r >= cfg_port_pkg::SEC3_LO && addr_r <= cfg_port_pkg::SEC3_HI);
  wire hit_iface = addr_r == cfg_port_pkg::ADDR_IFACE_CFG;
  wire hit_chan = addr_r == cfg_port_pkg::ADDR_CHAN_SEL;
  wire hit_scr = addr_r == cfg_port_pkg::ADDR_SCRATCH;
  wire hit_fmt = addr_r == cfg_port_pkg::ADDR_OUT_FMT;
  // both channel bits set reads channel a
  wire [7:0] fmt_rd = chan_r[0] ? fmt_a_r : fmt_b_r;
  wire [7:0] rd_val = !in_map ? 8'h00 :
    hit_iface ? iface_r : hit_chan ? chan_r : hit_scr ? scratch_r :
    hit_fmt ? fmt_rd : 8'h00;
  wire [7:0] rx_byte = lsb_first ? {sdi, shift_r[7:1]} : {shift_r[6:0], sdi};
  wire [15:0] rx_instr = lsb_first ? {sdi, instr_r[15:1]} : {instr_r[14:0], sdi};
  wire byte_done = sclk_rise && (bit_cnt_r[2:0] == cfg_port_pkg::BIT_CNT_LAST[2:0]);
  wire instr_done = sclk_rise && (bit_cnt_r == 5'h0F);
  wire wr_strobe = (state_r == ST_DATA) && byte_done && !is_read_r;
  wire [14:0] addr_step = ascend ? addr_r + 15'h0001 : addr_r - 15'h0001;
  wire srst_hit = wr_strobe && hit_iface && (rx_byte == cfg_port_pkg::SOFT_RESET_CMD);

  // frame sequencing; select high abandons any frame in flight
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      instr_r <= 16'h0000;
      shift_r <= 8'h00;
      is_read_r <= 1'b0;
      addr_r <= 15'h0000;
    end else if (sel_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sclk_rise) begin
            state_r <= ST_INSTR;
            instr_r <= rx_instr;
            bit_cnt_r <= 5'h01;
          end
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            instr_r <= rx_instr;
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
          if (instr_done) begin
            // msb first puts the rw bit at top, lsb first at bottom
            is_read_r <= lsb_first ? rx_instr[0] : rx_instr[15];
            addr_r <= lsb_first ? rx_instr[15:1] : rx_instr[14:0];
            state_r <= ST_DATA;
            bit_cnt_r <= 5'h00;
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            shift_r <= rx_byte;
            bit_cnt_r <= {2'b00, bit_cnt_r[2:0] + 3'h1};
          end
          if (byte_done) begin
            addr_r <= addr_step;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // register writes; soft reset restores the map and self-clears
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iface_r <= cfg_port_pkg::IFACE_CFG_RST;
      chan_r <= cfg_port_pkg::CHAN_SEL_RST;
      scratch_r <= cfg_port_pkg::SCRATCH_RST;
      fmt_a_r <= cfg_port_pkg::OUT_FMT_RST;
      fmt_b_r <= cfg_port_pkg::OUT_FMT_RST;
      srst_cnt_r <= 23'h00_0000;
    end else if (srst_hit) begin
      iface_r <= cfg_port_pkg::IFACE_CFG_RST;
      chan_r <= cfg_port_pkg::CHAN_SEL_RST;
      scratch_r <= cfg_port_pkg::SCRATCH_RST;
      fmt_a_r <= cfg_port_pkg::OUT_FMT_RST;
      fmt_b_r <= cfg_port_pkg::OUT_FMT_RST;
      srst_cnt_r <= 23'(cfg_port_pkg::SOFT_RESET_CYC);
    end else begin
      if (srst_cnt_r != 23'h00_0000) begin
        srst_cnt_r <= srst_cnt_r - 23'h00_0001;
      end
      if (wr_strobe && in_map) begin
        // mirror the lsb-first and ascend bits pairwise so lsb/msb views agree
        if (hit_iface) iface_r <= {1'b0, rx_byte[6:5], 2'b00, rx_byte[5], rx_byte[6], 1'b0};
        if (hit_chan) chan_r <= {6'h00, rx_byte[1:0]};
        if (hit_scr) scratch_r <= rx_byte;
        if (hit_fmt && chan_r[0]) fmt_a_r <= rx_byte;
        if (hit_fmt && chan_r[1]) fmt_b_r <= rx_byte;
      end
    end
  end

  // readback: load at byte start, shift out on falling clock edges
  wire load_rd = (state_r == ST_DATA) && is_read_r && (bit_cnt_r == 5'h00) && sclk_fall;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_r <= 8'h00;
      dout_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (sel_n) begin
      drive_r <= 1'b0;
    end else begin
      if (load_rd) begin
        // turn the wire only after the host let go at the falling edge
        drive_r <= 1'b1;
        tx_r <= lsb_first ? {1'b0, rd_val[7:1]} : {rd_val[6:0], 1'b0};
        dout_r <= lsb_first ? rd_val[0] : rd_val[7];
      end else if (sclk_fall && drive_r) begin
        tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        dout_r <= lsb_first ? tx_r[0] : tx_r[7];
      end
    end
  end

  // pin drive and user outputs
  assign link.dev_sdio_o = dout_r;
  assign link.dev_sdio_oe = drive_r;
  assign o_out_fmt = fmt_a_r;
  assign o_chan_sel = chan_r[1:0];
  assign o_soft_reset_busy = srst_cnt_r != 23'h00_0000;
  assign o_pins_idle = sel_n;
endmodule : cfg_port_device

`default_nettype wire

// ### logic/cfg_port_pkg.sv
// constants shared by both ends of the three-wire configuration port
// assumes one system clock on each end and a host-made serial clock
//
// Behaviour
// - frame starts at first shift-clock rise after select
// - select high makes device ignore clock and data
// - select held low streams bytes without limit
// - select may rise between bytes as pause; the device here ends the frame instead
// - select idle high leaves data pin undriven
// - all transfers are whole eight-bit words
// - first instruction bit chooses read or write
// - device drives data pin after read instruction
// - clock and select inputs; data pin turns around
// - msb first after reset, lsb first when configured
// - data sampled and shifted on serial clock
// - decode 0x000-0x00D and 0x015-0x24C byte registers
// - decode 0x300-0x387 and 0x550-0x5C5 registers
// - output format register resets to 0x01
// - host keeps port quiet during critical sampling
// - 0x81 to 0x000 soft resets; wait 5 ms
// - channel bits select local registers; both reads A
`default_nettype none

package cfg_port_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int ADDR_W = 15;
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [14:0] ADDR_IFACE_CFG = 15'h0000;
  localparam logic [14:0] ADDR_CHAN_SEL = 15'h0008;
  localparam logic [14:0] ADDR_SCRATCH = 15'h000A;
  localparam logic [14:0] ADDR_OUT_FMT = 15'h0561;
  localparam logic [14:0] SEC0_LO = 15'h0000;
  localparam logic [14:0] SEC0_HI = 15'h000D;
  localparam logic [14:0] SEC1_LO = 15'h0015;
  localparam logic [14:0] SEC1_HI = 15'h024C;
  localparam logic [14:0] SEC2_LO = 15'h0300;
  localparam logic [14:0] SEC2_HI = 15'h0387;
  localparam logic [14:0] SEC3_LO = 15'h0550;
  localparam logic [14:0] SEC3_HI = 15'h05C5;
  localparam logic [7:0] IFACE_CFG_RST = 8'h00;
  localparam logic [7:0] CHAN_SEL_RST = 8'h03;
  localparam logic [7:0] OUT_FMT_RST = 8'h01;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h81;
  localparam int IFACE_LSB_BIT = 6;
  localparam int IFACE_ASC_BIT = 5;
  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_HZ = 20000000;
  localparam int SOFT_RESET_MS = 5;
  localparam int SOFT_RESET_CYC = SYS_CLK_HZ / 1000 * SOFT_RESET_MS;
  localparam int SCLK_HALF_CYC = 4;
endpackage : cfg_port_pkg

`default_nettype wire

// ### logic/cfg_port_if.sv
// three-wire link between the configuration host and the device port
// resolves the shared data wire here from the two enables
`default_nettype none

interface cfg_port_if;
  logic port_select_n;
  logic sclk;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;
  // shared wire level: whoever enables drives, the host if both do; idle pulls high
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
  modport host (
    output port_select_n, sclk, host_sdio_o, host_sdio_oe,
    input sdio
  );
  modport device (
    input port_select_n, sclk, sdio,
    output dev_sdio_o, dev_sdio_oe
  );
endinterface : cfg_port_if

`default_nettype wire

// ### logic/cfg_port_host.sv
// host end: runs one frame per software request through a plain register port
// assumes the device samples pins with its own clock; sclk made here by a divider
`default_nettype none

module cfg_port_host (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // link
  cfg_port_if.host link
);
  // ****************************************
  // command register: [31] read, [30:16] addr, [7:0] data, [8] lsb first
  // ****************************************
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_DONE} host_state_t;
  host_state_t state_r;
  logic [23:0] sh_r;
  logic [7:0] rx_r;
  logic [4:0] bits_r;
  logic [2:0] div_r;
  logic sclk_r;
  logic sel_n_r;
  logic oe_r;
  logic rd_op_r;
  logic lsb_r;
  logic [31:0] rdata_r;
  logic meta_r;
  logic sdi_r;
  wire start = i_wr && (i_addr == REG_CMD) && (state_r == H_IDLE);
  wire tick = div_r == 3'(cfg_port_pkg::SCLK_HALF_CYC - 1);
  wire [23:0] frame_w = {i_wdata[31:16], i_wdata[7:0]};
  wire [23:0] frame_rev = {<<{frame_w}};

  // data pin synchroniser before the shift register reads it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= 1'b1;
      sdi_r <= 1'b1;
    end else begin
      meta_r <= link.sdio;
      sdi_r <= meta_r;
    end
  end

  // frame engine: 24 clocks, sclk low at idle, data changed on fall
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= H_IDLE;
      sh_r <= 24'h00_0000;
      rx_r <= 8'h00;
      bits_r <= 5'h00;
      div_r <= 3'h0;
      sclk_r <= 1'b0;
      sel_n_r <= 1'b1;
      oe_r <= 1'b0;
      rd_op_r <= 1'b0;
      lsb_r <= 1'b0;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (start) begin
            // lsb first: rw bit still first, then address and data each lsb first
            sh_r <= i_wdata[8] ? {frame_rev[0], frame_rev[15:1], frame_rev[23:16]} : frame_w;
            rd_op_r <= i_wdata[31];
            lsb_r <= i_wdata[8];
            sel_n_r <= 1'b0;
            oe_r <= 1'b1;
            bits_r <= 5'h00;
            div_r <= 3'h0;
            state_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_r <= tick ? 3'h0 : div_r + 3'h1;
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              // round trip through both synchronisers outlasts half a period,
              // so the returned bit is taken at the end of the high phase
              rx_r <= lsb_r ? {sdi_r, rx_r[7:1]} : {rx_r[6:0], sdi_r};
              sh_r <= {sh_r[22:0], 1'b0};
              bits_r <= bits_r + 5'h01;
              if (bits_r == 5'h0F && rd_op_r) oe_r <= 1'b0;
              if (bits_r == 5'h17) state_r <= H_DONE;
            end
          end
        end
        H_DONE: begin
          sel_n_r <= 1'b1;
          oe_r <= 1'b0;
          state_r <= H_IDLE;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // register read port, data one cycle after strobe
  wire [31:0] stat_w = {23'h00_0000, state_r != H_IDLE, rx_r};
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= (i_rd && i_addr == REG_STAT) ? stat_w : 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_r;
  assign link.port_select_n = sel_n_r;
  assign link.sclk = sclk_r;
  assign link.host_sdio_o = sh_r[23];
  assign link.host_sdio_oe = oe_r;
endmodule : cfg_port_host

`default_nettype wire

// ### test/cfg_port_sva.sv
// checker watching the three-wire link between the host and device ends
// assumes tb instantiates it beside the interface and feeds the link signals
`default_nettype none

module cfg_port_sva (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // link
  input wire logic port_select_n,
  input wire logic sclk,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_oe,
  input wire logic sdio
);
  localparam int FRAME_BITS = 24;
  logic [4:0] rise_cnt_r;
  logic sclk_d_r;
  // rises counted per frame; cleared while deselected so each frame starts at zero
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rise_cnt_r <= 5'h00;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk;
      if (port_select_n) begin
        rise_cnt_r <= 5'h00;
      end else if (sclk && !sclk_d_r) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // one high phase of the divided shift clock
  sequence high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  a_no_contention: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data wire");
  a_idle_release: assert property (port_select_n [*6] |-> !dev_sdio_oe)
    else $error("device drives while deselected");
  a_host_in_frame: assert property (host_sdio_oe |-> !port_select_n)
    else $error("host drives data outside a frame");
  // a quiet clock between frames keeps the port from disturbing sampling
  a_sclk_idle: assert property (port_select_n |-> !sclk)
    else $error("shift clock high while deselected");
  a_frame_start: assert property ($fell(port_select_n) |-> !sclk [*3])
    else $error("shift clock rose too soon after select");
  a_sclk_period: assert property ($rose(sclk) |-> high_phase)
    else $error("shift clock high phase wrong");
  a_data_stable: assert property (sclk && $past(sclk) |-> $stable(sdio))
    else $error("data moved while shift clock high");
  a_frame_length: assert property ($rose(port_select_n) |-> rise_cnt_r == FRAME_BITS)
    else $error("frame not three whole bytes");
  a_read_turn: assert property ($rose(dev_sdio_oe) |-> rise_cnt_r == 16)
    else $error("device turned the wire at wrong bit");
  a_host_release: assert property ($fell(host_sdio_oe) |->
      rise_cnt_r == 16 || rise_cnt_r == FRAME_BITS)
    else $error("host released the wire at wrong bit");
endmodule : cfg_port_sva

`default_nettype wire

// ### test/tb.sv
// self-checking bench: host and device ends joined by the link interface
// assumes the host register port (0 command, 1 status) and package constants
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [7:0] o_out_fmt;
  logic [1:0] o_chan_sel;
  logic o_soft_reset_busy;
  logic o_pins_idle;
  logic res_rd = 1'b0;
  logic res_rd_d = 1'b0;
  logic sclk_d = 1'b0;
  logic [23:0] sniff_r = 24'h00_0000;
  logic [7:0] exp_q[$];
  logic [7:0] rnd;
  logic [14:0] holes [4] = '{15'h0013, 15'h0300, 15'h05C5, 15'h0600};
  int fails = 0;
  int check_count = 0;
  integer seed = 14585;
  // ****************************************
  // ends, link and checker
  // ****************************************
  cfg_port_if link_if();
  cfg_port_device i_cfg_port_device (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .link(link_if.device), .o_out_fmt(o_out_fmt), .o_chan_sel(o_chan_sel),
    .o_soft_reset_busy(o_soft_reset_busy), .o_pins_idle(o_pins_idle));
  cfg_port_host i_cfg_port_host (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link_if.host));
  cfg_port_sva i_cfg_port_sva (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .port_select_n(link_if.port_select_n), .sclk(link_if.sclk),
    .host_sdio_oe(link_if.host_sdio_oe), .dev_sdio_oe(link_if.dev_sdio_oe), .sdio(link_if.sdio));
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // status polled until the frame is over; bounded so a hung frame ends the run
  task automatic poll_idle;
    int n;
    for (n = 0; n < 400; n++) begin
      i_addr <= 2'h1;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      if (o_rdata[8] === 1'b0) break;
      @(posedge i_sys_clk);
    end
    if (n == 400) begin
      fails++;
      test_done();
    end
    @(posedge i_sys_clk);
  endtask : poll_idle
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d, input logic lsb);
    i_addr <= 2'h0;
    i_wdata <= {rd, a, 7'h00, lsb, d};
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    poll_idle();
  endtask : frame
  // read frame, then its expectation is queued and the received byte fetched
  task automatic rd_reg(input logic [14:0] a, input logic lsb, input logic [7:0] e);
    frame(1'b1, a, 8'h00, lsb);
    exp_q.push_back(e);
    i_addr <= 2'h1;
    i_rd <= 1'b1;
    res_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    res_rd <= 1'b0;
    @(posedge i_sys_clk);
  endtask : rd_reg
  // monitor: read data stands the cycle after the strobe, so compare one edge later
  always @(posedge i_sys_clk) begin
    res_rd_d <= res_rd;
    if (res_rd_d) check(24'(o_rdata[7:0]), 24'(exp_q.pop_front()));
  end
  // wire sniffer: bit taken at each shift-clock rise inside a frame
  always @(posedge i_sys_clk) begin
    sclk_d <= link_if.sclk;
    if (link_if.sclk && !sclk_d && !link_if.port_select_n) begin
      sniff_r <= {sniff_r[22:0], link_if.sdio};
    end
  end
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(negedge i_sys_clk);
    check(24'(o_out_fmt), 24'(cfg_port_pkg::OUT_FMT_RST));
    check(24'(o_pins_idle), 24'h00_0001);
    check(24'(link_if.dev_sdio_oe), 24'h00_0000);
    @(posedge i_sys_clk);
    rd_reg(cfg_port_pkg::ADDR_OUT_FMT, 1'b0, 8'h01);
    rd_reg(cfg_port_pkg::ADDR_CHAN_SEL, 1'b0, cfg_port_pkg::CHAN_SEL_RST);
    rnd = 8'($random(seed));
    frame(1'b0, cfg_port_pkg::ADDR_SCRATCH, rnd, 1'b0);
    check(sniff_r, {1'b0, cfg_port_pkg::ADDR_SCRATCH, rnd});
    rd_reg(cfg_port_pkg::ADDR_SCRATCH, 1'b0, rnd);
    // unassigned and unimplemented places: writes lost, reads zero
    foreach (holes[i]) begin
      frame(1'b0, holes[i], 8'hA5, 1'b0);
      rd_reg(holes[i], 1'b0, 8'h00);
    end
    rd_reg(cfg_port_pkg::ADDR_SCRATCH, 1'b0, rnd);
    frame(1'b0, cfg_port_pkg::ADDR_CHAN_SEL, 8'h02, 1'b0);
    frame(1'b0, cfg_port_pkg::ADDR_OUT_FMT, 8'h55, 1'b0);
    check(24'(o_out_fmt), 24'h00_0001);
    rd_reg(cfg_port_pkg::ADDR_OUT_FMT, 1'b0, 8'h55);
    frame(1'b0, cfg_port_pkg::ADDR_CHAN_SEL, 8'h03, 1'b0);
    rd_reg(cfg_port_pkg::ADDR_OUT_FMT, 1'b0, 8'h01);
    frame(1'b0, cfg_port_pkg::ADDR_OUT_FMT, rnd, 1'b0);
    check(24'(o_out_fmt), 24'(rnd));
    check(24'(o_chan_sel), 24'h00_0003);
    // least significant bit first, then back again
    frame(1'b0, cfg_port_pkg::ADDR_IFACE_CFG, 8'h42, 1'b0);
    rd_reg(cfg_port_pkg::ADDR_SCRATCH, 1'b1, rnd);
    frame(1'b0, cfg_port_pkg::ADDR_SCRATCH, ~rnd, 1'b1);
    rd_reg(cfg_port_pkg::ADDR_SCRATCH, 1'b1, ~rnd);
    frame(1'b0, cfg_port_pkg::ADDR_IFACE_CFG, 8'h00, 1'b1);
    rd_reg(cfg_port_pkg::ADDR_SCRATCH, 1'b0, ~rnd);
    // soft reset last: its recovery outlasts the run
    frame(1'b0, cfg_port_pkg::ADDR_IFACE_CFG, cfg_port_pkg::SOFT_RESET_CMD, 1'b0);
    @(negedge i_sys_clk);
    check(24'(o_soft_reset_busy), 24'h00_0001);
    test_done();
  end
endmodule : tb

`default_nettype wire
